// >>> logic/ipv_pkg.sv
// package: constants and types of the interrupt priority vectoring block
// Function
// R1: sixteen sources, three priority levels
// R2: source needs own and global enable; power-fail here gated by own enable only
// R3: global enable low blocks all maskable
// R4: highest level only for power-fail
// R5: priority bit one selects high level
// R6: simultaneous same level: lower natural wins
// R7: ext2-5 and single-wire share vector 43h
// R8: single-wire enable overrides ext5 request
// R9: power-fail vector 33h, watchdog bits 4,5
// R10: ext0 03h prio 1, ext1 13h prio 3
// R11: timers 0,1,2 vector 0Bh,1Bh,2Bh
// R12: serial rx or tx raises port request
// R13: timer3 4Bh, write-protect 5Bh
// R14: CAN 6Bh, ethernet activity 73h
// R15: watchdog 63h, ethernet power mode 7Bh
// R16: software clears flags not auto-cleared
// R17: timer0/1 flags clear on service entry
// R18: ext0/1 edge clears, level follows pin
// R19: single-wire enables reached via master ports
// R20: in-service level blocks same or lower
package ipv_pkg;
  localparam int NUM_SRC = 16;
  localparam int IDX_W = 4;
  localparam logic [7:0] VEC_TABLE [NUM_SRC] = '{
    8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B,
    8'h43, 8'h4B, 8'h53, 8'h5B, 8'h6B, 8'h73, 8'h63, 8'h7B};
  localparam logic [IDX_W-1:0] SRC_PFAIL = 4'h0;
  localparam logic [IDX_W-1:0] SRC_EXT0 = 4'h1;
  localparam logic [IDX_W-1:0] SRC_TMR0 = 4'h2;
  localparam logic [IDX_W-1:0] SRC_EXT1 = 4'h3;
  localparam logic [IDX_W-1:0] SRC_TMR1 = 4'h4;
  localparam int WDC_PFAIL_FLAG_BIT = 4;
  localparam int WDC_PFAIL_EN_BIT = 5;
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_PFAIL = 2'b11
  } ipv_level_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01
  } ipv_state_t;
endpackage

// >>> logic/ipv_cand_if.sv
// interface: candidate request vectors between arbiter and top
`timescale 1ns/10ps
interface ipv_cand_if;
  logic [15:0] req;
  logic found;
  logic [3:0] idx;
  modport arb (input req, output found, idx);
  modport top (output req, input found, idx);
endinterface

// >>> logic/ipv_pick.sv
// module: fixed natural-order picker, lowest index wins
`timescale 1ns/10ps
module ipv_pick
(
  ipv_cand_if.arb c
);
  import ipv_pkg::*;
  always_comb
  begin
    c.found = 1'b0;
    c.idx = 4'h0;
    // R6: lowest wins
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (c.req[i])
      begin
        c.found = 1'b1;
        c.idx = IDX_W'(i);
      end
    end
  end
endmodule

// >>> logic/ipv_ctrl.sv
// module: interrupt controller top with flags, enables, priorities, vectoring
`timescale 1ns/10ps
module ipv_ctrl
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic i_global_irq_enable,
  input wire logic [15:0] i_src_enable,
  input wire logic [15:0] i_src_priority,
  input wire logic i_power_fail_flag,
  input wire logic i_power_fail_irq_enable,
  input wire logic i_ext0_pin_n,
  input wire logic i_ext1_pin_n,
  input wire logic i_ext0_edge_mode,
  input wire logic i_ext1_edge_mode,
  input wire logic i_timer0_overflow_set,
  input wire logic i_timer1_overflow_set,
  input wire logic i_timer0_flag_clear,
  input wire logic i_timer1_flag_clear,
  input wire logic i_ext0_flag_clear,
  input wire logic i_ext1_flag_clear,
  input wire logic i_timer2_overflow_flag,
  input wire logic i_timer3_overflow_flag,
  input wire logic [2:0] i_serial_rx_flag,
  input wire logic [2:0] i_serial_tx_flag,
  input wire logic [3:0] i_ext_group_flag,
  input wire logic i_single_wire_irq,
  input wire logic i_single_wire_master_irq_enable,
  input wire logic i_write_protect_flag,
  input wire logic i_can_irq,
  input wire logic i_buffer_unit_tx_flag,
  input wire logic i_buffer_unit_rx_flag,
  input wire logic i_watchdog_irq_flag,
  input wire logic i_ethernet_power_mode_flag,
  input wire logic i_ack,
  input wire logic i_reti,
  output logic o_irq_req,
  output logic [7:0] o_vector,
  output logic [3:0] o_src_idx,
  output logic o_ext0_flag,
  output logic o_ext1_flag,
  output logic o_timer0_overflow_flag,
  output logic o_timer1_overflow_flag,
  output logic [2:0] o_in_service
);
  import ipv_pkg::*;

  ipv_cand_if cand_pf ();
  ipv_cand_if cand_hi ();
  ipv_cand_if cand_lo ();

  logic ext0_flag_r, ext0_flag_nxt;
  logic ext1_flag_r, ext1_flag_nxt;
  logic ext0_pin_r, ext1_pin_r;
  logic tmr0_flag_r, tmr0_flag_nxt;
  logic tmr1_flag_r, tmr1_flag_nxt;
  logic [15:0] pend;
  logic [15:0] gated;
  logic [2:0] insvc_r, insvc_nxt;
  logic [2:0] svc_stack_r [3];
  logic [2:0] svc_stack_nxt [3];
  logic [1:0] depth_r, depth_nxt;
  ipv_state_t state_r, state_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic [3:0] idx_r, idx_nxt;
  ipv_level_t lvl_r, lvl_nxt;
  ipv_level_t win_lvl;
  logic [3:0] win_idx;
  logic win_found;
  logic ack_ext0, ack_ext1, ack_t0, ack_t1;

  assign ack_ext0 = (state_r == ST_REQ) && i_ack && (idx_r == SRC_EXT0);
  assign ack_ext1 = (state_r == ST_REQ) && i_ack && (idx_r == SRC_EXT1);
  assign ack_t0 = (state_r == ST_REQ) && i_ack && (idx_r == SRC_TMR0);
  assign ack_t1 = (state_r == ST_REQ) && i_ack && (idx_r == SRC_TMR1);

  // flag state
  always_comb
  begin
    // R18: edge flag clears on entry, set wins
    if (i_ext0_edge_mode)
    begin
      ext0_flag_nxt = ext0_flag_r;
      if (ack_ext0 || i_ext0_flag_clear)
        ext0_flag_nxt = 1'b0;
      if (ext0_pin_r && !i_ext0_pin_n)
        ext0_flag_nxt = 1'b1;
    end
    else
    begin
      // R18: level follows pin
      ext0_flag_nxt = !i_ext0_pin_n;
    end
    if (i_ext1_edge_mode)
    begin
      ext1_flag_nxt = ext1_flag_r;
      if (ack_ext1 || i_ext1_flag_clear)
        ext1_flag_nxt = 1'b0;
      if (ext1_pin_r && !i_ext1_pin_n)
        ext1_flag_nxt = 1'b1;
    end
    else
    begin
      ext1_flag_nxt = !i_ext1_pin_n;
    end
    // R17: timer flags clear on entry
    tmr0_flag_nxt = tmr0_flag_r;
    if (ack_t0 || i_timer0_flag_clear)
      tmr0_flag_nxt = 1'b0;
    if (i_timer0_overflow_set)
      tmr0_flag_nxt = 1'b1;
    tmr1_flag_nxt = tmr1_flag_r;
    if (ack_t1 || i_timer1_flag_clear)
      tmr1_flag_nxt = 1'b0;
    if (i_timer1_overflow_set)
      tmr1_flag_nxt = 1'b1;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      ext0_flag_r <= 1'b0;
      ext1_flag_r <= 1'b0;
      ext0_pin_r <= 1'b1;
      ext1_pin_r <= 1'b1;
      tmr0_flag_r <= 1'b0;
      tmr1_flag_r <= 1'b0;
    end
    else
    begin
      ext0_flag_r <= ext0_flag_nxt;
      ext1_flag_r <= ext1_flag_nxt;
      ext0_pin_r <= i_ext0_pin_n;
      ext1_pin_r <= i_ext1_pin_n;
      tmr0_flag_r <= tmr0_flag_nxt;
      tmr1_flag_r <= tmr1_flag_nxt;
    end
  end

  // pending requests in natural order
  always_comb
  begin
    // R9: power-fail flag
    pend[0] = i_power_fail_flag;
    // R10: external 0 and 1
    pend[1] = ext0_flag_r;
    pend[3] = ext1_flag_r;
    // R11: timer overflows
    pend[2] = tmr0_flag_r;
    pend[4] = tmr1_flag_r;
    pend[6] = i_timer2_overflow_flag;
    // R12: serial rx or tx
    pend[5] = i_serial_rx_flag[0] | i_serial_tx_flag[0];
    pend[7] = i_serial_rx_flag[1] | i_serial_tx_flag[1];
    pend[10] = i_serial_rx_flag[2] | i_serial_tx_flag[2];
    // R7: shared group; R8: single-wire overrides ext5
    pend[8] = (|i_ext_group_flag[2:0])
      | (i_single_wire_master_irq_enable ? i_single_wire_irq : i_ext_group_flag[3]);
    // R13: timer3 and write-protect
    pend[9] = i_timer3_overflow_flag;
    pend[11] = i_write_protect_flag;
    // R14: can and ethernet activity
    pend[12] = i_can_irq;
    pend[13] = i_buffer_unit_tx_flag | i_buffer_unit_rx_flag;
    // R15: watchdog and power mode
    pend[14] = i_watchdog_irq_flag;
    pend[15] = i_ethernet_power_mode_flag;
  end

  // R2: own and global enable, power-fail own only; R3: global gate
  assign gated = {pend[15:1] & i_src_enable[15:1] & {15{i_global_irq_enable}},
    pend[0] & i_power_fail_irq_enable};

  // R4: power-fail alone at top; R5: priority bit
  assign cand_pf.req = {15'h0, gated[0]};
  assign cand_hi.req = {gated[15:1] & i_src_priority[15:1], 1'b0};
  assign cand_lo.req = {gated[15:1] & ~i_src_priority[15:1], 1'b0};

  // R1: three levels arbitrated
  ipv_pick u_pick_pf (.c(cand_pf));
  ipv_pick u_pick_hi (.c(cand_hi));
  ipv_pick u_pick_lo (.c(cand_lo));

  // R20: only levels above in-service win
  always_comb
  begin
    win_found = 1'b0;
    win_idx = 4'h0;
    win_lvl = LVL_NONE;
    if (cand_pf.found && !insvc_r[2])
    begin
      win_found = 1'b1;
      win_idx = cand_pf.idx;
      win_lvl = LVL_PFAIL;
    end
    else if (cand_hi.found && (insvc_r[2:1] == 2'b00))
    begin
      win_found = 1'b1;
      win_idx = cand_hi.idx;
      win_lvl = LVL_HIGH;
    end
    else if (cand_lo.found && (insvc_r == 3'b000))
    begin
      win_found = 1'b1;
      win_idx = cand_lo.idx;
      win_lvl = LVL_LOW;
    end
  end

  // vectoring state
  always_comb
  begin
    state_nxt = state_r;
    vec_nxt = vec_r;
    idx_nxt = idx_r;
    lvl_nxt = lvl_r;
    insvc_nxt = insvc_r;
    depth_nxt = depth_r;
    svc_stack_nxt = svc_stack_r;
    case (state_r)
      ST_IDLE:
      begin
        if (win_found)
        begin
          state_nxt = ST_REQ;
          idx_nxt = win_idx;
          vec_nxt = VEC_TABLE[win_idx];
          lvl_nxt = win_lvl;
        end
      end
      ST_REQ:
      begin
        if (i_ack)
        begin
          state_nxt = ST_IDLE;
          svc_stack_nxt[depth_r] = insvc_r;
          depth_nxt = depth_r + 2'd1;
          case (lvl_r)
            LVL_PFAIL: insvc_nxt = insvc_r | 3'b100;
            LVL_HIGH: insvc_nxt = insvc_r | 3'b010;
            default: insvc_nxt = insvc_r | 3'b001;
          endcase
        end
        else if (!win_found)
          state_nxt = ST_IDLE;
        else
        begin
          // request withdrawn or outranked: refresh
          idx_nxt = win_idx;
          vec_nxt = VEC_TABLE[win_idx];
          lvl_nxt = win_lvl;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // R20: return restores previous level
    if (i_reti && depth_r != 2'd0 && !(state_r == ST_REQ && i_ack))
    begin
      depth_nxt = depth_r - 2'd1;
      insvc_nxt = svc_stack_r[depth_r - 2'd1];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state_r <= ST_IDLE;
      vec_r <= 8'h00;
      idx_r <= 4'h0;
      lvl_r <= LVL_NONE;
      insvc_r <= 3'h0;
      depth_r <= 2'h0;
      svc_stack_r <= '{3'h0, 3'h0, 3'h0};
    end
    else
    begin
      state_r <= state_nxt;
      vec_r <= vec_nxt;
      idx_r <= idx_nxt;
      lvl_r <= lvl_nxt;
      insvc_r <= insvc_nxt;
      depth_r <= depth_nxt;
      svc_stack_r <= svc_stack_nxt;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      o_irq_req <= 1'b0;
      o_vector <= 8'h00;
      o_src_idx <= 4'h0;
      o_ext0_flag <= 1'b0;
      o_ext1_flag <= 1'b0;
      o_timer0_overflow_flag <= 1'b0;
      o_timer1_overflow_flag <= 1'b0;
      o_in_service <= 3'h0;
    end
    else
    begin
      o_irq_req <= (state_nxt == ST_REQ);
      o_vector <= vec_nxt;
      o_src_idx <= idx_nxt;
      o_ext0_flag <= ext0_flag_nxt;
      o_ext1_flag <= ext1_flag_nxt;
      o_timer0_overflow_flag <= tmr0_flag_nxt;
      o_timer1_overflow_flag <= tmr1_flag_nxt;
      o_in_service <= insvc_nxt;
    end
  end
endmodule

// >>> test/ipv_ctrl_props.sv
// checker: port properties of the interrupt controller
`timescale 1ns/10ps
module ipv_ctrl_props
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic i_global_irq_enable,
  input wire logic [15:0] i_src_priority,
  input wire logic i_ext0_pin_n,
  input wire logic i_ext0_edge_mode,
  input wire logic i_timer0_overflow_set,
  input wire logic i_ack,
  input wire logic o_irq_req,
  input wire logic [7:0] o_vector,
  input wire logic [3:0] o_src_idx,
  input wire logic o_ext0_flag,
  input wire logic o_timer0_overflow_flag,
  input wire logic [2:0] o_in_service
);
  import ipv_pkg::*;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  chk_global_gate_off: assert property (
    !i_global_irq_enable [*3] |-> !o_irq_req || o_src_idx == SRC_PFAIL)
    else $error("maskable request with global enable low");
  chk_vector_by_src: assert property (
    o_irq_req |-> o_vector == VEC_TABLE[o_src_idx]) else $error("vector does not match source");
  chk_top_level_pfail: assert property (
    $rose(o_in_service[2]) |-> $past(i_ack) && $past(o_src_idx) == SRC_PFAIL)
    else $error("top level entered by other source");
  chk_ack_ends_req: assert property (
    i_ack && o_irq_req |=> !o_irq_req) else $error("request stands after ack");
  chk_low_lockout: assert property (
    o_irq_req && o_in_service[0] |-> o_src_idx == SRC_PFAIL || i_src_priority[o_src_idx])
    else $error("low request while low in service");
  chk_high_lockout: assert property (
    o_irq_req && o_in_service[1] |-> o_src_idx == SRC_PFAIL)
    else $error("request while high in service");
  chk_timer0_autoclear: assert property (
    i_ack && o_irq_req && o_src_idx == SRC_TMR0 && !i_timer0_overflow_set
    |=> !o_timer0_overflow_flag) else $error("timer0 flag kept after entry");
  chk_ext0_edge_clear: assert property (
    i_ack && o_irq_req && o_src_idx == SRC_EXT0 && i_ext0_edge_mode && !$fell(i_ext0_pin_n)
    |=> !o_ext0_flag) else $error("ext0 edge flag kept after entry");
  cov_pfail_entry: cover property (i_ack && o_irq_req && o_src_idx == SRC_PFAIL);
  cov_nested_high: cover property (o_in_service == 3'b011);
  cov_group_vector: cover property (o_irq_req && o_vector == 8'h43);
endmodule
bind ipv_ctrl ipv_ctrl_props u_props (.*);

// >>> test/ipv_core_model.sv
// core model: accepts vectors and returns from service
`timescale 1ns/10ps
module ipv_core_model
(
  input wire logic i_clk,
  input wire logic i_irq_req,
  input wire logic [7:0] i_vector,
  input wire logic [31:0] i_wait,
  output logic o_ack,
  output logic o_reti
);
  logic [7:0] taken_q [$];
  int cnt = 0;
  initial
  begin
    o_ack = 1'b0;
    o_reti = 1'b0;
  end
  // ack only while a request stands; delay lets a better one win
  always @(negedge i_clk)
  begin
    cnt = i_irq_req && !o_ack ? cnt + 1 : 0;
    if (o_ack)
      o_ack <= 1'b0;
    else if (i_irq_req && cnt > i_wait)
      o_ack <= 1'b1;
  end
  always @(posedge i_clk)
    if (o_ack && i_irq_req)
      taken_q.push_back(i_vector);
  task automatic ret();
    @(negedge i_clk);
    o_reti = 1'b1;
    @(negedge i_clk);
    o_reti = 1'b0;
  endtask
endmodule

// >>> test/ipv_ctrl_tb_top.sv
// testbench: interrupt controller against a reference picker
`timescale 1ns/10ps
module ipv_ctrl_tb_top;
  localparam int BIG = 1000000;
  localparam int VT [16] = '{'h33, 'h03, 'h0B, 'h13, 'h1B, 'h23, 'h2B, 'h3B,
    'h43, 'h4B, 'h53, 'h5B, 'h6B, 'h73, 'h63, 'h7B};
  logic I_CLK, I_RST_N, i_global_irq_enable, i_power_fail_irq_enable, alt, i_ack, i_reti;
  logic [15:0] i_src_enable, i_src_priority, src;
  logic i_power_fail_flag, i_ext0_pin_n, i_ext1_pin_n, i_ext0_edge_mode, i_ext1_edge_mode;
  logic i_timer0_overflow_set, i_timer1_overflow_set, i_timer0_flag_clear, i_timer1_flag_clear;
  logic i_ext0_flag_clear, i_ext1_flag_clear, i_timer2_overflow_flag, i_timer3_overflow_flag;
  logic [2:0] i_serial_rx_flag, i_serial_tx_flag, o_in_service;
  logic [3:0] i_ext_group_flag, o_src_idx;
  logic i_single_wire_irq, i_single_wire_master_irq_enable, i_write_protect_flag, i_can_irq;
  logic i_buffer_unit_tx_flag, i_buffer_unit_rx_flag, i_watchdog_irq_flag, o_irq_req;
  logic i_ethernet_power_mode_flag, o_ext0_flag, o_ext1_flag;
  logic o_timer0_overflow_flag, o_timer1_overflow_flag;
  logic [7:0] o_vector;
  int wt, exp, svc_e, lat, fail_count, n_compared;
  wire [3:0] fl = {o_timer1_overflow_flag, o_ext1_flag, o_timer0_overflow_flag, o_ext0_flag};
  assign i_power_fail_flag = src[0];
  assign i_ext0_pin_n = !src[1];
  assign i_timer0_overflow_set = src[2];
  assign i_ext1_pin_n = !src[3];
  assign i_timer1_overflow_set = src[4];
  assign i_serial_rx_flag = {src[10], src[7], src[5]} & {3{alt}};
  assign i_serial_tx_flag = {src[10], src[7], src[5]} & {3{!alt}};
  assign i_timer2_overflow_flag = src[6];
  assign i_timer3_overflow_flag = src[9];
  assign i_write_protect_flag = src[11];
  assign i_can_irq = src[12];
  assign i_buffer_unit_rx_flag = src[13] & alt;
  assign i_buffer_unit_tx_flag = src[13] & !alt;
  assign i_watchdog_irq_flag = src[14];
  assign i_ethernet_power_mode_flag = src[15];
  assign i_ext1_edge_mode = i_ext0_edge_mode;
  ipv_ctrl u_ipv_ctrl (.*);
  ipv_core_model u_ipv_core_model (.i_clk(I_CLK), .i_irq_req(o_irq_req), .i_vector(o_vector),
    .i_wait(wt), .o_ack(i_ack), .o_reti(i_reti));
  initial
  begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = !I_CLK;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // three levels, lowest index wins within one
  function automatic int pick(int p, int e, int h, int blk);
    for (int lv = 2; lv >= blk; lv--)
      for (int i = 0; i < 16; i++)
        if (p[i] && e[i] && (i == 0 ? 2 : h[i]) == lv)
          return i;
    return -1;
  endfunction
  task automatic look();
    int p, e;
    p = (src | lat) & 'hFEFF;
    p[8] = |i_ext_group_flag[2:0] ||
      (i_single_wire_master_irq_enable ? i_single_wire_irq : i_ext_group_flag[3]);
    e = i_global_irq_enable ? i_src_enable : 0;
    e[0] = i_power_fail_irq_enable;
    exp = pick(p, e, i_src_priority, svc_e[2] ? 3 : svc_e[1] ? 2 : svc_e[0]);
    chk("irq_req", exp >= 0, o_irq_req);
    if (exp >= 0)
    begin
      chk("vector", VT[exp], o_vector);
      chk("src_idx", exp, o_src_idx);
    end
  endtask
  task automatic serve();
    int n;
    n = u_ipv_core_model.taken_q.size();
    wt = $urandom % 3;
    for (int c = 0; c < 20 && u_ipv_core_model.taken_q.size() == n; c++)
      @(negedge I_CLK);
    wt = BIG;
    chk("taken", VT[exp], u_ipv_core_model.taken_q[$]);
    svc_e |= exp == 0 ? 4 : i_src_priority[exp] ? 2 : 1;
    chk("in_service", svc_e, o_in_service);
    src[exp] = 0;
    lat[exp] = 0;
    if (exp == 8)
      {i_ext_group_flag, i_single_wire_irq} = 0;
  endtask
  task automatic ret();
    u_ipv_core_model.ret();
    svc_e = svc_e[2] ? svc_e & 3 : svc_e[1] ? svc_e & 1 : 0;
    repeat (2) @(negedge I_CLK);
    chk("in_service", svc_e, o_in_service);
  endtask
  task automatic raise(int k);
    src[k] = 1'b1;
    repeat (3) @(negedge I_CLK);
    look();
    if (exp >= 0)
      serve();
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #1ms;
    fail_count++;
    summarize();
  end
  initial
  begin
    {I_RST_N, src, lat, svc_e, fail_count, n_compared, alt} = 0;
    {i_global_irq_enable, i_power_fail_irq_enable, i_src_enable, i_src_priority} = 0;
    {i_ext0_edge_mode, i_ext_group_flag, i_single_wire_irq, i_single_wire_master_irq_enable} = 0;
    {i_timer0_flag_clear, i_timer1_flag_clear, i_ext0_flag_clear, i_ext1_flag_clear} = 0;
    wt = BIG;
    repeat (6) @(negedge I_CLK);
    I_RST_N = 1'b1;
    void'($urandom(2783));
    repeat (80)
    begin
      @(negedge I_CLK);
      src = 16'($urandom & $urandom & 'hFEEB);
      {i_ext_group_flag, i_single_wire_irq, i_single_wire_master_irq_enable, alt} = 7'($urandom);
      i_src_enable = 16'($urandom);
      i_src_priority = 16'($urandom);
      i_global_irq_enable = $urandom % 4 != 0;
      i_power_fail_irq_enable = 1'($urandom);
      repeat (3) @(negedge I_CLK);
      chk("ext0_flag", src[1], o_ext0_flag);
      look();
      if (exp >= 0)
      begin
        serve();
        ret();
      end
      src = 0;
      {i_ext_group_flag, i_single_wire_irq} = 0;
      repeat (4) @(negedge I_CLK);
    end
    {i_global_irq_enable, i_power_fail_irq_enable, i_ext0_edge_mode} = 3'b111;
    i_src_enable = 16'hFFFF;
    i_src_priority = 16'h0200;
    // set beats a same-cycle clear, then software clear
    i_global_irq_enable = 1'b0;
    src[4:1] = 4'hF;
    {i_timer0_flag_clear, i_timer1_flag_clear, i_ext0_flag_clear, i_ext1_flag_clear} = 4'hF;
    @(negedge I_CLK);
    src[4:1] = 4'h0;
    {i_timer0_flag_clear, i_timer1_flag_clear, i_ext0_flag_clear, i_ext1_flag_clear} = 4'h0;
    @(negedge I_CLK);
    chk("set_wins", 8'h0F, fl);
    {i_timer0_flag_clear, i_timer1_flag_clear, i_ext0_flag_clear, i_ext1_flag_clear} = 4'hF;
    @(negedge I_CLK);
    {i_timer0_flag_clear, i_timer1_flag_clear, i_ext0_flag_clear, i_ext1_flag_clear} = 4'h0;
    @(negedge I_CLK);
    chk("sw_clear", 8'h00, fl);
    i_global_irq_enable = 1'b1;
    for (int k = 1; k < 5; k++)
    begin
      src[k] = 1'b1;
      @(negedge I_CLK);
      src[k] = 1'b0;
      lat[k] = 1;
      repeat (3) @(negedge I_CLK);
      chk("flag_set", 1, fl[k-1]);
      look();
      serve();
      chk("flag_entry", 0, fl[k-1]);
      ret();
    end
    raise(5);
    raise(12);
    raise(9);
    raise(0);
    repeat (3) ret();
    summarize();
  end
endmodule
